/* dv/eni_irq_sink.sv */
// interrupt controller model: counts high cycles per line
`timescale 1ns/100ps
module eni_irq_sink (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] irq_i,
    output int fault_cnt_o,
    output int recov_cnt_o,
    output int crit_cnt_o
);
    // a stuck line shows as a count too high
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_cnt_o <= 0;
            recov_cnt_o <= 0;
            crit_cnt_o <= 0;
        end else begin
            fault_cnt_o <= fault_cnt_o + irq_i[0];
            recov_cnt_o <= recov_cnt_o + irq_i[1];
            crit_cnt_o <= crit_cnt_o + irq_i[2];
        end
    end
endmodule

/* dv/eni_top_props.sv */
// port-level assertions for the error node block
`timescale 1ns/100ps
module eni_top_props #(
    parameter bit EDGE_MODE = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic er_rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic err_det_i,
    input wire logic [1:0] err_cls_i,
    input wire logic fault_irq_o,
    input wire logic recov_irq_o,
    input wire logic crit_irq_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // cycles since the last error or write, stuck at 7
    logic [2:0] since;
    wire logic any_irq = fault_irq_o | recov_irq_o | crit_irq_o;
    wire logic cause = (err_det_i && err_cls_i != 2'h0)
        || (pready_o && pwrite_i);
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since <= 3'h7;
        end else if (cause) begin
            since <= 3'h0;
        end else if (since != 3'h7) begin
            since <= since + 3'h1;
        end
    end

    a_cold_quiet: assert property (disable iff (1'b0)
        !rst_n_i |-> !any_irq) else $error("irq in reset");
    a_rise_cause: assert property (
        ($rose(fault_irq_o) || $rose(recov_irq_o) || $rose(crit_irq_o))
        |-> since <= 3'h3) else $error("irq rose uncaused");
    a_pulse_cause: assert property (
        EDGE_MODE && any_irq |-> since == 3'h0)
        else $error("late pulse");
    a_er_quiet: assert property (
        !er_rst_n_i [*6] |-> !any_irq) else $error("irq in recovery");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    a_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access");
    a_slverr_ready: assert property (pslverr_o |-> pready_o)
        else $error("slverr alone");
    a_data_idle: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("stray rdata");
    a_answer_time: assert property (disable iff (!rst_n_i || !er_rst_n_i)
        psel_i && $rose(penable_i) |=> pready_o)
        else $error("late ready");
endmodule

bind eni_top eni_top_props #(.EDGE_MODE(EDGE_MODE)) eni_top_props_inst (.*);

/* dv/test_error_node_irq_signaling.sv */
// bench: level and pulse builds against one record model
`timescale 1ns/100ps
module test_error_node_irq_signaling;
    logic ref_clk = 1'b0, er_rst_n = 1'b1, rst_n;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic err_det = 1'b0, err_crit = 1'b0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] err_cls = 2'h0;
    logic [15:0] err_synd = 16'h0;
    logic [31:0] prdata [2];
    logic [31:0] q0, q1;
    logic [1:0] pready, pslverr, fault, recov, crit;
    int fcnt, rcnt, ccnt, ef, er, ec;
    int errors = 0, checks = 0, cyc = 0;
    logic [31:0] seed = 32'hF5EA;
    // record model
    logic [4:0] ctrl;
    logic v, ue, de, ce, ci, of;
    logic [7:0] cnt;
    logic [15:0] synd;

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // index 0 level build, 1 pulse build
    for (genvar g = 0; g < 2; g++) begin : gen_mode
        eni_top #(.EDGE_MODE(g == 1)) eni_top_inst (
            .ref_clk_i(ref_clk), .rst_n_i(rst_n), .er_rst_n_i(er_rst_n),
            .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
            .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata[g]),
            .pready_o(pready[g]), .pslverr_o(pslverr[g]),
            .err_det_i(err_det), .err_cls_i(err_cls), .err_crit_i(err_crit),
            .err_synd_i(err_synd), .fault_irq_o(fault[g]),
            .recov_irq_o(recov[g]), .crit_irq_o(crit[g]));
    end
    eni_irq_sink eni_irq_sink_inst (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .irq_i({crit[1], recov[1], fault[1]}), .fault_cnt_o(fcnt),
        .recov_cnt_o(rcnt), .crit_cnt_o(ccnt));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q0,
                       output logic [31:0] q1, output logic e);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready[0] !== 1'b1 && n < 16);
        q0 = prdata[0];
        q1 = prdata[1];
        e = pslverr[0];
        chk("pready", 32'h1, {31'h0, pready[0]});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q0, q1, e);
        if (a == eni_pkg::A_CTRL) ctrl = d[4:0];
        if (a == eni_pkg::A_CECNT) cnt = d[7:0];
        if (a == eni_pkg::A_STAT) {v, ue, de, ce, ci, of} = 6'h00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x0,
                      input logic [31:0] x1, input logic xe);
        apb(1'b0, a, 32'h0, q0, q1, e);
        chk("rdata_level", x0, q0);
        chk("rdata_pulse", x1, q1);
        chk("slverr", {31'h0, xe}, {31'h0, e});
    endtask

    // settle, then compare with the model
    task automatic cmp();
        logic lf, lr, lc;
        logic [31:0] st;
        lf = v && ((ctrl[0] && (de || ue)) || (ctrl[1] && of));
        lr = v && ((ctrl[2] && ue) || (ctrl[3] && de));
        lc = v && ctrl[4] && ci;
        st = {25'h0, of, ci, 1'b0, ce, de, ue, v};
        repeat (3) @(posedge ref_clk);
        chk("fault_level", {31'h0, lf}, {31'h0, fault[0]});
        chk("recov_level", {31'h0, lr}, {31'h0, recov[0]});
        chk("crit_level", {31'h0, lc}, {31'h0, crit[0]});
        chk("fault_pulses", ef, fcnt);
        chk("recov_pulses", er, rcnt);
        chk("crit_pulses", ec, ccnt);
        rd(eni_pkg::A_CTRL, {27'h0, ctrl}, {27'h0, ctrl}, 1'b0);
        rd(eni_pkg::A_STAT, st, st, 1'b0);
        rd(eni_pkg::A_SYND, {16'h0, synd}, {16'h0, synd}, 1'b0);
        rd(eni_pkg::A_CECNT, {24'h0, cnt}, {24'h0, cnt}, 1'b0);
    endtask

    // one error; disabled critical counts as uncorrected
    task automatic err(input logic [1:0] c, input logic k);
        logic [31:0] s;
        logic [1:0] eff, cur;
        s = xs();
        @(posedge ref_clk);
        err_det <= 1'b1;
        err_cls <= c;
        err_crit <= k;
        err_synd <= s[15:0];
        @(posedge ref_clk);
        err_det <= 1'b0;
        err_cls <= s[17:16];
        eff = (k && !ctrl[4]) ? 2'h3 : c;
        cur = ue ? 2'h3 : de ? 2'h2 : (v && ce) ? 2'h1 : 2'h0;
        if (c == 2'h1) begin
            cnt = cnt + 8'h01;
            if (cnt == 8'h00) begin
                {of, v} = 2'h3;
                ef += int'(ctrl[1]);
            end
        end
        if (c != 2'h0) begin
            if (eff >= cur) begin
                {v, ue, de, ce, ci} = {1'b1, eff == 2'h3, eff == 2'h2,
                                       eff == 2'h1, k};
                synd = s[15:0];
            end
            ef += int'(ctrl[0] && eff >= 2'h2);
            er += int'((ctrl[2] && eff == 2'h3) || (ctrl[3] && eff == 2'h2));
            ec += int'(ctrl[4] && k);
        end
        cmp();
    endtask

    task automatic mreset();
        {ctrl, v, ue, de, ce, ci, of, cnt, synd} = '0;
        {ef, er, ec} = '0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // run takes ~1400 cycles; a hang is cut off
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 12000) begin
            errors++;
            $display("ERROR run_length expected 12000 seen %0d", cyc);
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] r, t1, t2, tb, fe;
        logic [1:0] c;
        // x to 0 at time zero gives the asynchronous reset its edge
        rst_n <= 1'b0;
        fe = {26'h0, 1'b0, 1'b1, eni_pkg::CI_SUPPORTED, eni_pkg::TS_LOCAL};
        mreset();
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        cmp();
        wr(eni_pkg::A_FEAT, 32'hFFFFFFFF);
        rd(eni_pkg::A_FEAT, fe, fe | 32'h20, 1'b0);
        rd(8'h04, 32'h0, 32'h0, 1'b1);
        err(2'h0, 1'b0);
        // random enables, classes, critical marks
        for (int i = 0; i < 40; i++) begin
            r = xs();
            if (r[5]) wr(eni_pkg::A_STAT, 32'h7F);
            wr(eni_pkg::A_CTRL, {27'h0, r[4:0]});
            c = (r[7:6] == 2'h0) ? 2'h3 : r[7:6];
            err(c, r[8] && c != 2'h1);
        end
        wr(eni_pkg::A_STAT, 32'h7F);
        wr(eni_pkg::A_CTRL, 32'h02);
        wr(eni_pkg::A_CECNT, 32'hFE);
        err(2'h1, 1'b0);
        err(2'h1, 1'b0);
        wr(eni_pkg::A_STAT, 32'h7F);
        err(2'h3, 1'b0);
        apb(1'b0, eni_pkg::A_TSTMP, 32'h0, t1, q1, e);
        apb(1'b0, eni_pkg::A_TBASE, 32'h0, tb, q1, e);
        chk("stamp_before_base", 32'h1, {31'h0, t1 < tb});
        err(2'h2, 1'b0);
        apb(1'b0, eni_pkg::A_TSTMP, 32'h0, t2, q1, e);
        chk("stamp_kept", t1, t2);
        err(2'h3, 1'b0);
        apb(1'b0, eni_pkg::A_TSTMP, 32'h0, t2, q1, e);
        chk("stamp_renewed", 32'h1, {31'h0, t2 > tb});
        apb(1'b0, eni_pkg::A_TBASE, 32'h0, t1, q1, e);
        chk("base_rising", 32'h1, {31'h0, t1 > t2});
        // recovery reset with all requests raised
        wr(eni_pkg::A_CTRL, 32'h1F);
        err(2'h3, 1'b1);
        er_rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk("irq_recovery", 32'h0, {29'h0, fault[0], recov[0], crit[0]});
        er_rst_n <= 1'b1;
        ctrl = 5'h00;
        repeat (3) @(posedge ref_clk);
        cmp();
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        mreset();
        cmp();
        report_and_stop();
    end
endmodule

/* logic/eni_irq_req.sv */
// one interrupt request line, level or pulse form, registered
`timescale 1ns/100ps
module eni_irq_req #(
    parameter bit EDGE = 1'b0,
    parameter bit WR_EDGE = 1'b0
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic lvl_i,
    input wire logic evt_i,
    input wire logic wr_i,
    output logic req_o
);
    typedef struct packed {
        logic lvl_q;
        logic req;
    } eni_req_st_t;

    eni_req_st_t s;
    eni_req_st_t next_s;

    // pulse form: one cycle per event, plus optional pulse when a
    // register write makes the level condition rise
    always_comb begin
        next_s.lvl_q = lvl_i;
        if (EDGE) begin
            next_s.req = evt_i;
            if (WR_EDGE && wr_i && lvl_i && !s.lvl_q) begin
                next_s.req = 1'b1;
            end
        end else begin
            next_s.req = lvl_i;
        end
        if (clr_i) begin
            next_s = '0;
        end
    end

    // outputs low during cold reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign req_o = s.req;
endmodule

/* logic/eni_pkg.sv */
// shared constants, error node interrupt block
package eni_pkg;
    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] A_FEAT = 8'h00;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_SYND = 8'h14;
    localparam logic [7:0] A_CECNT = 8'h18;
    localparam logic [7:0] A_TSTMP = 8'h1C;
    localparam logic [7:0] A_IRQ = 8'h20;
    localparam logic [7:0] A_TBASE = 8'h24;

    // ------------------------------------------------------------------
    // error_control_reg fields
    // ------------------------------------------------------------------
    localparam int CTL_W = 5;
    localparam int CTL_FI = 0;
    localparam int CTL_CFI = 1;
    localparam int CTL_UI = 2;
    localparam int CTL_DI = 3;
    localparam int CTL_CI = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int ST_V = 0;
    localparam int ST_UE = 1;
    localparam int ST_DE = 2;
    localparam int ST_CE = 3;
    localparam int ST_CI = 5;
    localparam int ST_OF = 6;
    localparam logic [1:0] CE_SET = 2'h1;

    // ------------------------------------------------------------------
    // feature_reg fields
    // ------------------------------------------------------------------
    localparam int FR_TS = 0;
    localparam int FR_CI = 2;
    localparam int FR_CEC = 4;
    localparam int FR_EDGE = 5;
    localparam logic [1:0] CI_SUPPORTED = 2'h1;
    localparam logic [1:0] TS_NONE = 2'h0;
    localparam logic [1:0] TS_LOCAL = 2'h1;

    // ------------------------------------------------------------------
    // error classes, ordered by priority
    // ------------------------------------------------------------------
    localparam logic [1:0] CLS_NONE = 2'h0;
    localparam logic [1:0] CLS_CE = 2'h1;
    localparam logic [1:0] CLS_DE = 2'h2;
    localparam logic [1:0] CLS_UE = 2'h3;

    // ------------------------------------------------------------------
    // widths and reset levels
    // ------------------------------------------------------------------
    localparam int SYND_W = 16;
    localparam int CNT_W = 8;
    localparam int TB_W = 32;
    localparam logic SYNC_RST = 1'b1;
endpackage

/* logic/eni_sync.sv */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module eni_sync (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } eni_sync_st_t;

    eni_sync_st_t s;
    eni_sync_st_t next_s;

    // first stage feeds only the second stage
    always_comb begin
        next_s.s1 = d_i;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= {eni_pkg::SYNC_RST, eni_pkg::SYNC_RST};
        end else begin
            s <= next_s;
        end
    end

    assign q_o = s.s2;
endmodule

/* logic/eni_top.sv */
// error node record, apb registers and interrupt request generation
//
// How it works
// - level fault: enable, valid, deferred or uncorrected
// - level fault: corrected enable, valid, counter overflow
// - level fault without counter: valid, corrected field
// - level recovery: uncorrected enable, valid, uncorrected
// - level recovery: deferred enable, valid, deferred
// - level critical: enable, valid, critical flag
// - pulse fault on enabled deferred or uncorrected detection
// - pulse fault on enabled corrected event
// - pulse recovery on enabled uncorrected error
// - pulse recovery on enabled deferred error
// - pulse critical on every enabled critical record
// - pulse even when syndrome is discarded
// - optional pulse when a write creates condition
// - outputs follow events within bounded cycles
// - build parameter picks pulse or level outputs
// - cold reset clears every state bit except the synchroniser flops, which reset to 1
// - recovery reset keeps recorded syndrome
// - timestamp captured when error is recorded
// - overwritten record gets new timestamp
// - discarded error leaves timestamp unchanged
// - two-bit feature field reports timestamp support
// - timebase is plain binary, monotonic, fixed rate
// - critical interrupt enabled only while bit is 1
// - corrected event: overflow or each corrected error
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module eni_top #(
    parameter bit EDGE_MODE = 1'b0,
    parameter bit WR_EDGE = 1'b0,
    parameter bit HAS_CE_CNT = 1'b1,
    parameter logic [1:0] TS_SEL = eni_pkg::TS_LOCAL
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic er_rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic err_det_i,
    input wire logic [1:0] err_cls_i,
    input wire logic err_crit_i,
    input wire logic [15:0] err_synd_i,
    output logic fault_irq_o,
    output logic recov_irq_o,
    output logic crit_irq_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [eni_pkg::CTL_W-1:0] ctrl;
        logic vld;
        logic ue;
        logic de;
        logic [1:0] ce;
        logic ci;
        logic ovf;
        logic [eni_pkg::SYND_W-1:0] synd;
        logic [eni_pkg::CNT_W-1:0] cecnt;
        logic [eni_pkg::TB_W-1:0] tbase;
        logic [eni_pkg::TB_W-1:0] tstamp;
        logic rdy;
        logic slverr;
        logic [31:0] rdata;
        logic wr_q;
    } eni_top_st_t;

    eni_top_st_t s;
    eni_top_st_t next_s;

    logic er_rst_n;
    logic er_clr;
    logic acc;
    logic wr_take;
    logic mapped;
    logic [1:0] cls_eff;
    logic [1:0] cur_cls;
    logic take;
    logic ce_evt;
    logic [eni_pkg::CNT_W:0] cnt_sum;
    logic fault_lvl;
    logic recov_lvl;
    logic crit_lvl;
    logic fault_evt;
    logic recov_evt;
    logic crit_evt;
    logic [31:0] feat;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // error-recovery reset pin
    // ------------------------------------------------------------------
    // pin is asynchronous to the node clock
    eni_sync u_er_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(er_rst_n_i),
        .q_o(er_rst_n)
    );
    assign er_clr = !er_rst_n;

    // ------------------------------------------------------------------
    // error classification
    // ------------------------------------------------------------------
    // critical with interrupt disabled is treated as uncorrected
    always_comb begin
        cls_eff = err_cls_i;
        if (err_crit_i && !s.ctrl[eni_pkg::CTL_CI]) begin
            cls_eff = eni_pkg::CLS_UE;
        end
        if (s.ue) begin
            cur_cls = eni_pkg::CLS_UE;
        end else if (s.de) begin
            cur_cls = eni_pkg::CLS_DE;
        end else if (s.ce != 2'h0) begin
            cur_cls = eni_pkg::CLS_CE;
        end else begin
            cur_cls = eni_pkg::CLS_NONE;
        end
    end

    // lower priority error leaves the record
    assign take = err_det_i && (cls_eff != eni_pkg::CLS_NONE)
        && (!s.vld || cls_eff >= cur_cls);

    // corrected-error counter; carry out is the overflow
    assign cnt_sum = {1'b0, s.cecnt} + {{eni_pkg::CNT_W{1'b0}}, 1'b1};

    // event depends on whether the counter is built
    always_comb begin
        if (HAS_CE_CNT) begin
            ce_evt = err_det_i && cls_eff == eni_pkg::CLS_CE
                && cnt_sum[eni_pkg::CNT_W];
        end else begin
            ce_evt = err_det_i && cls_eff == eni_pkg::CLS_CE;
        end
    end

    // ------------------------------------------------------------------
    // event terms for pulse form
    // ------------------------------------------------------------------
    // taken from detection, not from the record, so a discarded
    // syndrome still raises its request
    always_comb begin
        fault_evt = 1'b0;
        recov_evt = 1'b0;
        crit_evt = 1'b0;
        if (s.ctrl[eni_pkg::CTL_FI] && err_det_i
            && (cls_eff == eni_pkg::CLS_DE
            || cls_eff == eni_pkg::CLS_UE)) begin
            fault_evt = 1'b1;
        end
        if (s.ctrl[eni_pkg::CTL_CFI] && ce_evt) begin
            fault_evt = 1'b1;
        end
        if (s.ctrl[eni_pkg::CTL_UI] && err_det_i
            && cls_eff == eni_pkg::CLS_UE) begin
            recov_evt = 1'b1;
        end
        if (s.ctrl[eni_pkg::CTL_DI] && err_det_i
            && cls_eff == eni_pkg::CLS_DE) begin
            recov_evt = 1'b1;
        end
        if (s.ctrl[eni_pkg::CTL_CI] && err_det_i && err_crit_i) begin
            crit_evt = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // level terms from the record
    // ------------------------------------------------------------------
    always_comb begin
        fault_lvl = s.ctrl[eni_pkg::CTL_FI] && s.vld
            && (s.de || s.ue);
        if (HAS_CE_CNT) begin
            fault_lvl = fault_lvl || (s.ctrl[eni_pkg::CTL_CFI]
                && s.vld && s.ovf);
        end else begin
            fault_lvl = fault_lvl || (s.ctrl[eni_pkg::CTL_CFI]
                && s.vld && s.ce != 2'h0);
        end
        recov_lvl = (s.ctrl[eni_pkg::CTL_UI] && s.vld && s.ue)
            || (s.ctrl[eni_pkg::CTL_DI] && s.vld && s.de);
        crit_lvl = s.ctrl[eni_pkg::CTL_CI] && s.vld && s.ci;
    end

    // ------------------------------------------------------------------
    // read side of the register file
    // ------------------------------------------------------------------
    always_comb begin
        feat = 32'h0;
        feat[eni_pkg::FR_TS +: 2] = TS_SEL;
        feat[eni_pkg::FR_CI +: 2] = eni_pkg::CI_SUPPORTED;
        feat[eni_pkg::FR_CEC] = HAS_CE_CNT;
        feat[eni_pkg::FR_EDGE] = EDGE_MODE;
        stat_word = 32'h0;
        stat_word[eni_pkg::ST_V] = s.vld;
        stat_word[eni_pkg::ST_UE] = s.ue;
        stat_word[eni_pkg::ST_DE] = s.de;
        stat_word[eni_pkg::ST_CE +: 2] = s.ce;
        stat_word[eni_pkg::ST_CI] = s.ci;
        stat_word[eni_pkg::ST_OF] = s.ovf;
        mapped = 1'b1;
        rd_mux = 32'h0;
        case (paddr_i)
            eni_pkg::A_FEAT: rd_mux = feat;
            eni_pkg::A_CTRL: begin
                rd_mux[eni_pkg::CTL_W-1:0] = s.ctrl;
            end
            eni_pkg::A_STAT: rd_mux = stat_word;
            eni_pkg::A_SYND: begin
                rd_mux[eni_pkg::SYND_W-1:0] = s.synd;
            end
            eni_pkg::A_CECNT: begin
                rd_mux[eni_pkg::CNT_W-1:0] = s.cecnt;
            end
            eni_pkg::A_TSTMP: rd_mux = s.tstamp;
            eni_pkg::A_IRQ: begin
                rd_mux[2:0] = {crit_irq_o, recov_irq_o, fault_irq_o};
            end
            eni_pkg::A_TBASE: rd_mux = s.tbase;
            default: mapped = 1'b0;
        endcase
    end

    // first access cycle arms pready, second ends it
    assign acc = psel_i && penable_i;
    assign wr_take = acc && s.rdy && pwrite_i && !s.slverr;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.wr_q = 1'b0;
        // free running, cleared only by cold reset
        next_s.tbase = s.tbase + 32'h1;
        // bus handshake: one wait state before pready
        if (acc && !s.rdy) begin
            next_s.rdy = 1'b1;
            next_s.slverr = !mapped;
            next_s.rdata = pwrite_i ? 32'h0 : rd_mux;
        end else begin
            next_s.rdy = 1'b0;
            next_s.slverr = 1'b0;
            next_s.rdata = 32'h0000_0000;
        end
        // software writes first, hardware sets below win over them
        if (wr_take) begin
            case (paddr_i)
                eni_pkg::A_CTRL: begin
                    next_s.ctrl = pwdata_i[eni_pkg::CTL_W-1:0];
                    next_s.wr_q = 1'b1;
                end
                eni_pkg::A_STAT: begin
                    // write one to clear
                    next_s.vld = s.vld & ~pwdata_i[eni_pkg::ST_V];
                    next_s.ue = s.ue & ~pwdata_i[eni_pkg::ST_UE];
                    next_s.de = s.de & ~pwdata_i[eni_pkg::ST_DE];
                    next_s.ce = s.ce & ~pwdata_i[eni_pkg::ST_CE +: 2];
                    next_s.ci = s.ci & ~pwdata_i[eni_pkg::ST_CI];
                    next_s.ovf = s.ovf & ~pwdata_i[eni_pkg::ST_OF];
                    next_s.wr_q = 1'b1;
                end
                eni_pkg::A_CECNT: begin
                    next_s.cecnt = pwdata_i[eni_pkg::CNT_W-1:0];
                    next_s.wr_q = 1'b1;
                end
                default: begin
                    next_s.wr_q = 1'b0;
                end
            endcase
        end
        // corrected errors count even when not recorded, unless a critical mark with its interrupt disabled makes them uncorrected
        if (HAS_CE_CNT && err_det_i && cls_eff == eni_pkg::CLS_CE) begin
            next_s.cecnt = cnt_sum[eni_pkg::CNT_W-1:0];
            if (cnt_sum[eni_pkg::CNT_W]) begin
                next_s.ovf = 1'b1;
                next_s.vld = 1'b1;
            end
        end
        // record the new error or drop its syndrome and time
        if (take) begin
            next_s.vld = 1'b1;
            next_s.synd = err_synd_i;
            next_s.ue = cls_eff == eni_pkg::CLS_UE;
            next_s.de = cls_eff == eni_pkg::CLS_DE;
            next_s.ce = (cls_eff == eni_pkg::CLS_CE) ? eni_pkg::CE_SET
                : 2'h0;
            next_s.ci = err_crit_i;
            if (TS_SEL != eni_pkg::TS_NONE) begin
                next_s.tstamp = s.tbase;
            end
        end
        // recovery reset: operating logic only, syndrome kept
        if (er_clr) begin
            next_s.ctrl = eni_pkg::CTRL_RST;
            next_s.rdy = 1'b0;
            next_s.slverr = 1'b0;
            next_s.rdata = 32'h0000_0000;
            next_s.wr_q = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
            s.ctrl <= eni_pkg::CTRL_RST;
        end else begin
            s <= next_s;
        end
    end

    assign prdata_o = s.rdata;
    assign pready_o = s.rdy;
    assign pslverr_o = s.slverr;

    // ------------------------------------------------------------------
    // request lines
    // ------------------------------------------------------------------
    // level form lags the record by one flop; pulse form lags the
    // detection by one flop, so both settle within two edges
    eni_irq_req #(.EDGE(EDGE_MODE), .WR_EDGE(WR_EDGE)) u_fault (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(er_clr),
        .lvl_i(fault_lvl),
        .evt_i(fault_evt),
        .wr_i(s.wr_q),
        .req_o(fault_irq_o)
    );

    eni_irq_req #(.EDGE(EDGE_MODE), .WR_EDGE(WR_EDGE)) u_recov (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(er_clr),
        .lvl_i(recov_lvl),
        .evt_i(recov_evt),
        .wr_i(s.wr_q),
        .req_o(recov_irq_o)
    );

    eni_irq_req #(.EDGE(EDGE_MODE), .WR_EDGE(WR_EDGE)) u_crit (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clr_i(er_clr),
        .lvl_i(crit_lvl),
        .evt_i(crit_evt),
        .wr_i(s.wr_q),
        .req_o(crit_irq_o)
    );
endmodule
